// ==== design/acc_params.svh ====
// Register offsets, field positions, reset values and levels of the comparator control
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH

// Register bus geometry and register offsets
`define ACC_ADDR_W 4
`define ACC_DATA_W 8
`define ACC_OFS_CTRL_B 4'h0
`define ACC_OFS_CSR 4'h1
`define ACC_OFS_DIS0 4'h2

// Reset values
`define ACC_RST_CTRL_B 8'h00
`define ACC_RST_CSR 8'h00
`define ACC_RST_DIS0 8'h00

// Comparator control and status fields
`define ACC_CSR_POWER_OFF 7
`define ACC_CSR_INT_REF 6
`define ACC_CSR_RESULT 5
`define ACC_CSR_FLAG 4
`define ACC_CSR_IRQ_EN 3
`define ACC_CSR_CAPTURE 2
`define ACC_CSR_EDGE_HI 1
`define ACC_CSR_EDGE_LO 0

// Converter control B fields
`define ACC_CTB_MUX_EN 6
`define ACC_CTB_DIV_HI 5
`define ACC_CTB_DIV_LO 4
`define ACC_CTB_TRIG_HI 2
`define ACC_CTB_TRIG_LO 0

// Input buffer disable fields
`define ACC_DIS_POS 7
`define ACC_DIS_NEG 6

// Analog levels in millivolts, channel count and highest legal channel code
`define ACC_LEVEL_W 12
`define ACC_NUM_CHAN 11
`define ACC_CHAN_MAX 5'h0A
`define ACC_REF_FULL_MV 12'hA00
`define ACC_REF_SRC_INT 2'h3
`define ACC_LEVEL_ZERO 12'h000

`endif

// ==== design/acc_pkg.sv ====
// Types shared by the comparator control modules
package acc_pkg;

    // Event selection of the two-bit edge select field
    typedef enum logic [1:0] {
        ACC_EDGE_TOGGLE = 2'h0,
        ACC_EDGE_RSVD = 2'h1,
        ACC_EDGE_FALL = 2'h2,
        ACC_EDGE_RISE = 2'h3
    } acc_edge_mode_t;

endpackage : acc_pkg

// ==== design/acc_evt_if.sv ====
// Carrier between the control core and the edge detector
`timescale 1ns/1ps

interface acc_evt_if;
    logic result;
    acc_pkg::acc_edge_mode_t mode;
    logic hit;

    // Core drives result and mode, detector answers with a hit
    modport src (output result, output mode, input hit);
    modport det (input result, input mode, output hit);
endinterface : acc_evt_if

// ==== design/acc_sync.sv ====
// Two flip-flop synchroniser for asynchronous levels
`timescale 1ns/1ps

module acc_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_reg;

    // First stage is read only by the second stage
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            meta_reg <= '0;
            sync_o <= '0;
        end
        else
        begin
            meta_reg <= async_i;
            sync_o <= meta_reg;
        end
    end
endmodule : acc_sync

// ==== design/acc_edge_detect.sv ====
// Edge detector on the synchronised comparator result
`timescale 1ns/1ps

module acc_edge_detect (
    input wire logic clk_i,
    input wire logic rst_n_i,
    acc_evt_if.det evt
);
    logic prev_reg;

    // Previous result, sampled every clock
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            prev_reg <= 1'b0;
        else
            prev_reg <= evt.result; // RQ20
    end

    // Match the transition against the selected mode
    always_comb
    begin
        case (evt.mode)
            acc_pkg::ACC_EDGE_TOGGLE: evt.hit = evt.result ^ prev_reg; // RQ3
            acc_pkg::ACC_EDGE_FALL: evt.hit = prev_reg & ~evt.result; // RQ3
            acc_pkg::ACC_EDGE_RISE: evt.hit = ~prev_reg & evt.result; // RQ3
            default: evt.hit = 1'b0; // RQ20
        endcase
    end
endmodule : acc_edge_detect

// ==== design/acc_compare_ctrl.sv ====
// Control and status logic around the analog voltage comparator
//
// Overview of operation
// RQ1 - Raw result high when positive exceeds negative
// RQ2 - Result bit passes a two-stage synchroniser
// RQ3 - Edge field: toggle, reserved, falling, rising
// RQ4 - Matching transition sets event flag bit 4
// RQ5 - Vector execution clears the event flag
// RQ6 - Writing one clears flag, zero keeps it
// RQ7 - Interrupt needs flag, enable bit 3, global enable
// RQ8 - Power-off bit 7 stops comparator, zero restarts
// RQ9 - Software disables interrupt before power change
// RQ10 - Software disables interrupt before edge change
// RQ11 - Capture bit 2 routes result to timer capture
// RQ12 - Software also enables the timer capture interrupt
// RQ13 - Reference select bit 6 replaces negative input
// RQ14 - Divider bits 5 and 4 pick reference level
// RQ15 - Internal source gives full, half, quarter, eighth
// RQ16 - Mux enable with converter off picks channel
// RQ17 - Otherwise the dedicated positive pin is used
// RQ18 - Channel codes 0 to 10 select inputs
// RQ19 - Input disable bits force port reads zero
// RQ20 - Edge detector compares current and previous result
// RQ21 - Powered-off comparator holds its result constant
`timescale 1ns/1ps
`include "acc_params.svh"

module acc_compare_ctrl (
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [`ACC_ADDR_W-1:0] addr_i,
    input wire logic [`ACC_DATA_W-1:0] wr_data_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    output logic [`ACC_DATA_W-1:0] rd_data_o,
    // Converter and processor context
    input wire logic converter_enable_i,
    input wire logic [4:0] channel_select_i,
    input wire logic [1:0] ref_source_select_i,
    input wire logic cpu_global_irq_enable_i,
    input wire logic irq_vector_ack_i,
    // Analog levels in millivolts
    input wire logic [`ACC_LEVEL_W-1:0] pos_pin_level_i,
    input wire logic [`ACC_LEVEL_W-1:0] neg_pin_level_i,
    input wire logic [`ACC_NUM_CHAN*`ACC_LEVEL_W-1:0] chan_level_i,
    // Digital levels of the comparator pins
    input wire logic pos_pin_i,
    input wire logic neg_pin_i,
    // Outputs
    output logic irq_o,
    output logic capture_src_o,
    output logic cmp_power_off_o,
    output logic cmp_event_flag_o,
    output logic [2:0] auto_trigger_select_o,
    output logic pos_pin_read_o,
    output logic neg_pin_read_o
);
    // Register storage
    logic power_off_reg;
    logic int_ref_reg;
    logic flag_reg;
    logic irq_en_reg;
    logic capture_reg;
    logic [1:0] edge_sel_reg;
    logic mux_en_reg;
    logic [1:0] ref_div_reg;
    logic [2:0] trig_sel_reg;
    logic [`ACC_DATA_W-1:0] dis0_reg;
    logic result_reg;

    // Reset images of the control and status register and converter control B, so fields can be picked by position
    localparam logic [`ACC_DATA_W-1:0] csr_rst_val = `ACC_RST_CSR;
    localparam logic [`ACC_DATA_W-1:0] ctb_rst_val = `ACC_RST_CTRL_B;

    // Combinational terms
    logic [`ACC_LEVEL_W-1:0] chan_arr [0:`ACC_NUM_CHAN-1];
    logic [`ACC_LEVEL_W-1:0] pos_level;
    logic [`ACC_LEVEL_W-1:0] neg_level;
    logic [`ACC_LEVEL_W-1:0] ref_level;
    logic neg_valid;
    logic raw_cmp;
    logic [2:0] sync_out;
    logic sel_csr;
    logic sel_ctb;
    logic sel_dis;
    logic flag_clear;
    logic [`ACC_DATA_W-1:0] rd_next;

    acc_evt_if evt_bus ();

    // Unpack the channel level vector
    genvar gi;
    generate
        for (gi = 0; gi < `ACC_NUM_CHAN; gi++)
        begin : g_chan
            assign chan_arr[gi] = chan_level_i[gi*`ACC_LEVEL_W +: `ACC_LEVEL_W];
        end
    endgenerate

    // Positive input selection
    always_comb
    begin
        pos_level = pos_pin_level_i; // RQ17
        if (mux_en_reg && !converter_enable_i) // RQ16
        begin
            if (channel_select_i <= `ACC_CHAN_MAX)
                pos_level = chan_arr[channel_select_i[3:0]]; // RQ18
            else
                pos_level = `ACC_LEVEL_ZERO;
        end
    end

    // Internal reference scaled by the divider code
    assign ref_level = `ACC_REF_FULL_MV >> ref_div_reg; // RQ14 RQ15

    // Negative input selection; reserved source settings disable the compare
    always_comb
    begin
        neg_level = neg_pin_level_i;
        neg_valid = 1'b1;
        if (int_ref_reg) // RQ13
        begin
            if (ref_source_select_i == `ACC_REF_SRC_INT) // RQ15
                neg_level = ref_level;
            else
            begin
                neg_level = `ACC_LEVEL_ZERO;
                neg_valid = 1'b0;
            end
        end
    end

    // Comparator proper: behaves as the analog stage ahead of the synchroniser
    assign raw_cmp = !power_off_reg && neg_valid && (pos_level > neg_level); // RQ1

    // Synchronise the comparator output and both pin levels
    acc_sync #(
        .W(3)
    ) u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .async_i({neg_pin_i, pos_pin_i, raw_cmp}),
        .sync_o(sync_out)
    );

    // Result register follows the synchroniser unless powered off
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            result_reg <= 1'b0;
        else if (!power_off_reg)
            result_reg <= sync_out[0]; // RQ2
        else
            result_reg <= result_reg; // RQ21
    end

    // Edge detection on the synchronised result
    assign evt_bus.result = result_reg;
    assign evt_bus.mode = acc_pkg::acc_edge_mode_t'(edge_sel_reg);

    acc_edge_detect u_edge (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .evt(evt_bus)
    );

    // Address decode
    assign sel_csr = (addr_i == `ACC_OFS_CSR);
    assign sel_ctb = (addr_i == `ACC_OFS_CTRL_B);
    assign sel_dis = (addr_i == `ACC_OFS_DIS0);
    assign flag_clear = (wr_en_i && sel_csr && wr_data_i[`ACC_CSR_FLAG]) // RQ6
        || irq_vector_ack_i; // RQ5

    // Event flag: a new event wins over a clear in the same cycle
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            flag_reg <= 1'b0;
        else if (evt_bus.hit)
            flag_reg <= 1'b1; // RQ4
        else if (flag_clear)
            flag_reg <= 1'b0; // RQ5 RQ6
    end

    // Power-off bit; may change at any time, so software masks the interrupt first
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            power_off_reg <= csr_rst_val[`ACC_CSR_POWER_OFF];
        else if (wr_en_i && sel_csr)
            power_off_reg <= wr_data_i[`ACC_CSR_POWER_OFF]; // RQ8
    end

    // Internal reference select for the negative input
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            int_ref_reg <= csr_rst_val[`ACC_CSR_INT_REF];
        else if (wr_en_i && sel_csr)
            int_ref_reg <= wr_data_i[`ACC_CSR_INT_REF]; // RQ13
    end

    // Comparator interrupt enable
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            irq_en_reg <= csr_rst_val[`ACC_CSR_IRQ_EN];
        else if (wr_en_i && sel_csr)
            irq_en_reg <= wr_data_i[`ACC_CSR_IRQ_EN]; // RQ7
    end

    // Routing of the result toward the timer capture front end
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            capture_reg <= csr_rst_val[`ACC_CSR_CAPTURE];
        else if (wr_en_i && sel_csr)
            capture_reg <= wr_data_i[`ACC_CSR_CAPTURE]; // RQ11
    end

    // Edge select; a change may raise a stray event, so software masks first
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            edge_sel_reg <= csr_rst_val[`ACC_CSR_EDGE_HI:`ACC_CSR_EDGE_LO];
        else if (wr_en_i && sel_csr)
            edge_sel_reg <= wr_data_i[`ACC_CSR_EDGE_HI:`ACC_CSR_EDGE_LO]; // RQ3
    end

    // Positive multiplexer enable; bits 7 and 3 of this register read zero
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            mux_en_reg <= ctb_rst_val[`ACC_CTB_MUX_EN];
        else if (wr_en_i && sel_ctb)
            mux_en_reg <= wr_data_i[`ACC_CTB_MUX_EN]; // RQ16
    end

    // Internal reference divider code
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            ref_div_reg <= ctb_rst_val[`ACC_CTB_DIV_HI:`ACC_CTB_DIV_LO];
        else if (wr_en_i && sel_ctb)
            ref_div_reg <= wr_data_i[`ACC_CTB_DIV_HI:`ACC_CTB_DIV_LO]; // RQ14
    end

    // Auto trigger source, handed on to the converter
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            trig_sel_reg <= ctb_rst_val[`ACC_CTB_TRIG_HI:`ACC_CTB_TRIG_LO];
        else if (wr_en_i && sel_ctb)
            trig_sel_reg <= wr_data_i[`ACC_CTB_TRIG_HI:`ACC_CTB_TRIG_LO];
    end

    // Input buffer disable register
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            dis0_reg <= `ACC_RST_DIS0;
        else if (wr_en_i && sel_dis)
            dis0_reg <= wr_data_i;
    end

    // Read multiplexer; unmapped addresses read zero
    always_comb
    begin
        rd_next = 8'h00;
        case (addr_i)
            `ACC_OFS_CSR:
            begin
                rd_next[`ACC_CSR_POWER_OFF] = power_off_reg;
                rd_next[`ACC_CSR_INT_REF] = int_ref_reg;
                rd_next[`ACC_CSR_RESULT] = result_reg; // RQ2
                rd_next[`ACC_CSR_FLAG] = flag_reg;
                rd_next[`ACC_CSR_IRQ_EN] = irq_en_reg;
                rd_next[`ACC_CSR_CAPTURE] = capture_reg;
                rd_next[`ACC_CSR_EDGE_HI:`ACC_CSR_EDGE_LO] = edge_sel_reg;
            end
            `ACC_OFS_CTRL_B:
            begin
                rd_next[`ACC_CTB_MUX_EN] = mux_en_reg;
                rd_next[`ACC_CTB_DIV_HI:`ACC_CTB_DIV_LO] = ref_div_reg;
                rd_next[`ACC_CTB_TRIG_HI:`ACC_CTB_TRIG_LO] = trig_sel_reg;
            end
            `ACC_OFS_DIS0: rd_next = dis0_reg;
            default: rd_next = 8'h00;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            rd_data_o <= 8'h00;
        else if (rd_en_i)
            rd_data_o <= rd_next;
        else
            rd_data_o <= 8'h00;
    end

    // Interrupt request gated by enable and global enable
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            irq_o <= 1'b0;
        else
            irq_o <= flag_reg && irq_en_reg && cpu_global_irq_enable_i; // RQ7
    end

    // Result routed to the timer capture front end
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            capture_src_o <= 1'b0;
        else
            capture_src_o <= capture_reg & result_reg; // RQ11
    end

    // Pin reads through the synchroniser, forced low when buffer is off
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            pos_pin_read_o <= 1'b0;
            neg_pin_read_o <= 1'b0;
        end
        else
        begin
            pos_pin_read_o <= sync_out[1] & ~dis0_reg[`ACC_DIS_POS]; // RQ19
            neg_pin_read_o <= sync_out[2] & ~dis0_reg[`ACC_DIS_NEG]; // RQ19
        end
    end

    // Configuration and flag copies for the analog stage and the converter
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            cmp_power_off_o <= 1'b0;
            cmp_event_flag_o <= 1'b0;
            auto_trigger_select_o <= 3'h0;
        end
        else
        begin
            cmp_power_off_o <= power_off_reg; // RQ8
            cmp_event_flag_o <= flag_reg;
            auto_trigger_select_o <= trig_sel_reg;
        end
    end

endmodule : acc_compare_ctrl

// ==== testbench/acc_ctrl_monitor.sv ====
// Concurrent checks on the comparator control ports
`timescale 1ns/1ps
`include "acc_params.svh"

module acc_ctrl_monitor (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [`ACC_ADDR_W-1:0] addr_i,
    input wire logic [`ACC_DATA_W-1:0] wr_data_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    input wire logic [`ACC_DATA_W-1:0] rd_data_o,
    input wire logic cpu_global_irq_enable_i,
    input wire logic irq_vector_ack_i,
    input wire logic irq_o,
    input wire logic cmp_power_off_o,
    input wire logic cmp_event_flag_o,
    input wire logic [2:0] auto_trigger_select_o,
    input wire logic pos_pin_read_o,
    input wire logic neg_pin_read_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // Any cause that may clear the flag
    logic clr_cause;
    assign clr_cause = irq_vector_ack_i
        || (wr_en_i && addr_i == `ACC_OFS_CSR && wr_data_i[`ACC_CSR_FLAG]);

    // Register write steps and a six-cycle power-off run
    sequence s_csr_wr;
        wr_en_i && addr_i == `ACC_OFS_CSR;
    endsequence
    sequence s_ctb_wr;
        wr_en_i && addr_i == `ACC_OFS_CTRL_B;
    endsequence
    sequence s_dis_wr;
        wr_en_i && addr_i == `ACC_OFS_DIS0;
    endsequence
    sequence s_off_long;
        cmp_power_off_o [*6];
    endsequence

    property p_power;
        logic v;
        (s_csr_wr, v = wr_data_i[7]) |-> ##2 cmp_power_off_o == v;
    endproperty
    property p_trig;
        logic [2:0] v;
        (s_ctb_wr, v = wr_data_i[2:0]) |-> ##2 auto_trigger_select_o == v;
    endproperty

    a_rd_idle_zero: assert property (!rd_en_i |=> rd_data_o == 8'h00)
        else $error("read data not zero outside a read");
    a_unmapped_zero: assert property (rd_en_i && addr_i > `ACC_OFS_DIS0 |=> rd_data_o == 8'h00)
        else $error("unmapped read not zero");
    a_irq_needs_flag: assert property (irq_o |-> cmp_event_flag_o && $past(cpu_global_irq_enable_i))
        else $error("interrupt without flag and global enable");
    a_glob_off_quiet: assert property (!cpu_global_irq_enable_i |=> !irq_o)
        else $error("interrupt while global enable low");
    a_irq_en_off: assert property (s_csr_wr ##0 !wr_data_i[3] |-> ##2 !irq_o)
        else $error("interrupt after enable cleared");
    a_flag_clear_cause: assert property ($fell(cmp_event_flag_o) |-> $past(clr_cause) || $past(clr_cause, 2))
        else $error("flag fell without clear");
    a_off_no_event: assert property (s_off_long |-> !$rose(cmp_event_flag_o))
        else $error("event while powered off");
    a_power_follows: assert property (p_power)
        else $error("power-off output not following write");
    a_trig_follows: assert property (p_trig)
        else $error("trigger select not following write");
    a_pos_dis_zero: assert property (s_dis_wr ##0 wr_data_i[7] |-> ##2 !pos_pin_read_o)
        else $error("disabled positive pin reads one");
    a_neg_dis_zero: assert property (s_dis_wr ##0 wr_data_i[6] |-> ##2 !neg_pin_read_o)
        else $error("disabled negative pin reads one");
endmodule : acc_ctrl_monitor

bind acc_compare_ctrl acc_ctrl_monitor acc_ctrl_monitor_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
    .cpu_global_irq_enable_i(cpu_global_irq_enable_i), .irq_vector_ack_i(irq_vector_ack_i),
    .irq_o(irq_o), .cmp_power_off_o(cmp_power_off_o), .cmp_event_flag_o(cmp_event_flag_o),
    .auto_trigger_select_o(auto_trigger_select_o), .pos_pin_read_o(pos_pin_read_o),
    .neg_pin_read_o(neg_pin_read_o)
);

// ==== testbench/acc_far_model.sv ====
// Far side: digital levels of the analog pins and timer capture input
`timescale 1ns/1ps

module acc_far_model #(
    parameter int THRESH_MV = 2500
) (
    input wire logic clk_i,
    input wire logic [11:0] pos_mv_i,
    input wire logic [11:0] neg_mv_i,
    input wire logic capture_src_i,
    input wire logic capture_irq_enable_i,
    output logic pos_pin_o,
    output logic neg_pin_o,
    output int capture_count_o
);
    logic cap_prev = 1'b0;

    // Pin buffers see a logic one above the threshold
    assign pos_pin_o = pos_mv_i > THRESH_MV;
    assign neg_pin_o = neg_mv_i > THRESH_MV;

    // Capture interrupts counted only when the timer mask allows them
    initial capture_count_o = 0;
    always @(posedge clk_i)
    begin
        cap_prev <= capture_src_i;
        if (capture_src_i && !cap_prev && capture_irq_enable_i)
            capture_count_o <= capture_count_o + 1;
    end
endmodule : acc_far_model

// ==== testbench/testbench.sv ====
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
`include "acc_params.svh"

module testbench;
    logic clk, rst_n, we, re, cen, ge, ack, cie, irq, cap, pwr, flg, ppr, npr, pp, np;
    logic [3:0] a;
    logic [7:0] wd, rdo, rv;
    logic [4:0] ch;
    logic [1:0] rs;
    logic [2:0] ats;
    logic [11:0] pmv, nmv, lv;
    logic [131:0] chl;
    logic [15:0] lfsr;
    int failures, check_count, capn, m;

    acc_compare_ctrl acc_compare_ctrl_inst (.clk_i(clk), .rst_n_i(rst_n), .addr_i(a),
        .wr_data_i(wd), .wr_en_i(we), .rd_en_i(re), .rd_data_o(rdo), .converter_enable_i(cen),
        .channel_select_i(ch), .ref_source_select_i(rs), .cpu_global_irq_enable_i(ge),
        .irq_vector_ack_i(ack), .pos_pin_level_i(pmv), .neg_pin_level_i(nmv), .chan_level_i(chl),
        .pos_pin_i(pp), .neg_pin_i(np), .irq_o(irq), .capture_src_o(cap),
        .cmp_power_off_o(pwr), .cmp_event_flag_o(flg), .auto_trigger_select_o(ats),
        .pos_pin_read_o(ppr), .neg_pin_read_o(npr));
    acc_far_model acc_far_model_inst (.clk_i(clk), .pos_mv_i(pmv), .neg_mv_i(nmv),
        .capture_src_i(cap), .capture_irq_enable_i(cie), .pos_pin_o(pp), .neg_pin_o(np),
        .capture_count_o(capn));

    // Clock at 100 MHz
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : nxt

    task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
        check_count++;
        if (g !== e)
        begin
            failures++;
            $display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask : step

    task automatic wr(input logic [3:0] ra, input logic [7:0] d);
        @(posedge clk);
        a <= ra;
        wd <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask : wr

    // Read data sampled in the cycle after the strobe
    task automatic rd(input logic [3:0] ra);
        @(posedge clk);
        a <= ra;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1 rv = rdo;
    endtask : rd

    task automatic stop_test;
        if (failures == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test

    // Run limit
    initial
    begin
        #400000;
        failures++;
        stop_test;
    end

    // Main sequence
    initial
    begin
        {we, re, cen, ge, ack, cie, a, wd, ch, rs, pmv, chl} = '0;
        nmv = 12'h064;
        lfsr = 16'hFE03;
        failures = 0;
        check_count = 0;
        rst_n = 1'b0;
        step(8);
        rst_n <= 1'b1;
        for (int r = 0; r < 6; r++)
        begin
            rd(r[3:0]);
            chk("reset read", 12'h000, rv);
        end
        wr(4'h0, 8'hFF);
        rd(4'h0);
        chk("ctrl b", 12'h077, rv);
        chk("trigger", 12'h007, ats);
        wr(4'h0, 8'h00);
        // Every edge mode on a rise then a fall
        for (m = 0; m < 4; m++)
        begin
            wr(4'h1, 8'h10 | m[7:0]);
            pmv <= 12'h12C;
            step(6);
            rd(4'h1);
            chk("rise", {m == 0 || m == 3, 4'h0}, rv[4:0] & 5'h10);
            chk("result", 12'h001, rv[5]);
            wr(4'h1, 8'h10 | m[7:0]);
            pmv <= 12'h000;
            step(6);
            chk("fall", m == 0 || m == 2, flg);
            wr(4'h1, 8'h10 | m[7:0]);
        end
        // Interrupt, vector clear, global and local enable
        ge <= 1'b1;
        wr(4'h1, 8'h1B);
        pmv <= 12'h12C;
        step(6);
        chk("irq", 12'h001, irq);
        ack <= 1'b1;
        step(1);
        ack <= 1'b0;
        step(3);
        chk("ack", 12'h000, {irq, flg});
        ge <= 1'b0;
        pmv <= 12'h000;
        step(6);
        pmv <= 12'h12C;
        step(6);
        chk("global off", 12'h001, {irq, flg});
        ge <= 1'b1;
        step(3);
        chk("global on", 12'h001, irq);
        wr(4'h1, 8'h03);
        step(3);
        chk("w0 keeps", 12'h001, {irq, flg});
        wr(4'h1, 8'h13);
        step(3);
        chk("w1 clears", 12'h000, flg);
        // Power-off freezes the result
        wr(4'h1, 8'h90);
        step(6);
        wr(4'h1, 8'h90);
        for (int i = 0; i < 4; i++)
        begin
            pmv <= i[0] ? 12'h12C : 12'h000;
            step(6);
        end
        rd(4'h1);
        chk("off", 12'h0A0, rv);
        wr(4'h1, 8'h00);
        step(6);
        chk("on", 12'h000, pwr);
        // Internal reference levels
        rs <= 2'h3;
        wr(4'h1, 8'h40);
        for (int d = 0; d < 4; d++)
        begin
            wr(4'h0, d[1:0] << 4);
            pmv <= (12'hA00 >> d) + 12'h008;
            step(6);
            rd(4'h1);
            chk("ref above", 12'h001, rv[5]);
            pmv <= (12'hA00 >> d) - 12'h008;
            step(6);
            rd(4'h1);
            chk("ref below", 12'h000, rv[5]);
        end
        rs <= 2'h0;
        pmv <= 12'hFA0;
        step(6);
        rd(4'h1);
        chk("ref reserved", 12'h000, rv[5]);
        // Channel routing with random levels
        wr(4'h1, 8'h00);
        wr(4'h0, 8'h40);
        nmv <= 12'h3E8;
        pmv <= 12'h000;
        for (int c = 0; c < 11; c++)
        begin
            lfsr = nxt(lfsr);
            lv = lfsr[11:0] & 12'h7FF;
            chl[c*12 +: 12] <= lv;
            ch <= c[4:0];
            step(6);
            rd(4'h1);
            chk("channel", lv > 12'h3E8, rv[5]);
        end
        chl[0 +: 12] <= 12'hFFF;
        ch <= 5'h10;
        step(6);
        rd(4'h1);
        chk("channel reserved", 12'h000, rv[5]);
        ch <= 5'h00;
        cen <= 1'b1;
        step(6);
        rd(4'h1);
        chk("converter on", 12'h000, rv[5]);
        // Capture routing toward the timer
        cie <= 1'b1;
        wr(4'h1, 8'h04);
        pmv <= 12'hBB8;
        step(6);
        chk("capture", 12'h001, cap);
        chk("capture count", 12'h001, capn);
        wr(4'h1, 8'h00);
        step(3);
        chk("no capture", 12'h000, cap);
        // Digital pin reads and their disable bits
        nmv <= 12'hBB8;
        step(6);
        chk("pins", 12'h003, {ppr, npr});
        wr(4'h2, 8'hC0);
        step(3);
        chk("pins off", 12'h000, {ppr, npr});
        rd(4'h2);
        chk("disable reg", 12'h0C0, rv);
        stop_test;
    end
endmodule : testbench
